// >>> include/udt_consts.vh
// Constants for the up/down reload capture timer
`ifndef UDT_CONSTS_VH
`define UDT_CONSTS_VH

`define UDT_ADDR_CTRL 8'hc8
`define UDT_ADDR_MODE 8'hc9
`define UDT_ADDR_RCL 8'hca
`define UDT_ADDR_RCH 8'hcb
`define UDT_ADDR_CNTL 8'hcc
`define UDT_ADDR_CNTH 8'hcd

`define UDT_CTRL_RESET 8'h00
`define UDT_MODE_RESET 8'h00
`define UDT_BYTE_ZERO 8'h00

// Control register bit positions
`define UDT_B_OVF 7
`define UDT_B_EXT 6
`define UDT_B_RXB 5
`define UDT_B_TXB 4
`define UDT_B_PINEN 3
`define UDT_B_RUN 2
`define UDT_B_CSEL 1
`define UDT_B_CAP 0
// Mode register bit positions
`define UDT_B_CLKOE 1
`define UDT_B_DOWN_COUNT_ENABLE 0
`define UDT_MODE_MASK 8'h03
// Highest software-owned control bit
`define UDT_CTRL_SW_MSB 5

`define UDT_CNT_MAX 16'hffff
`define UDT_CNT_MIN 16'h0000
`define UDT_CNT_ONE 16'h0001
`define UDT_PS_ZERO 4'h0
`define UDT_PS_ONE 4'h1
`define UDT_BAUD_DIV_LAST 4'hf
`define UDT_BAUD_ONE 4'h1

`endif

// >>> src/udt_byte_reg.v
// Byte-wide register pair holding the reload/capture value
`timescale 1ns/1ps
`include "udt_consts.vh"

module udt_byte_reg (
    input wire clk_in,
    input wire rstn_in,
    input wire ce_in,
    input wire wr_lo_in,
    input wire wr_hi_in,
    input wire [7:0] wdata_in,
    input wire cap_in,
    input wire [15:0] cap_data_in,
    output reg [15:0] value_out
);

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            value_out <= `UDT_CNT_MIN;
        end else if (ce_in) begin
            if (cap_in) begin
                value_out <= cap_data_in;
            end else begin
                if (wr_lo_in) begin
                    value_out[7:0] <= wdata_in;
                end
                if (wr_hi_in) begin
                    value_out[15:8] <= wdata_in;
                end
            end
        end
    end

endmodule

// >>> src/udt_timer.v
// 16-bit up/down reload and capture timer with baud and clock-out
//
// Function
// - Timer function counts system clocks divided by prescale 1 to 16.
// - Counter function counts 1-to-0 pin samples; value visible next cycle.
// - Mode priority: off, baud, capture, up/down reload, up reload.
// - Capture mode counts 0000h to ffffh, wraps, sets overflow flag.
// - Capture mode trigger falling edge captures count, sets event flag.
// - Capture and up reload: both flags request the timer interrupt.
// - Up reload: overflow sets flag and loads reload value.
// - Up reload: trigger falling edge also reloads and sets event flag.
// - Down-count enable resets to zero, so reload counts up.
// - Down-count with trigger high counts up, reloads on overflow.
// - Down-count with trigger low counts down, underflow loads ffffh.
// - Up/down mode toggles event flag on wrap; that flag raises no interrupt.
// - Baud mode high byte rollover reloads count from reload value.
// - Baud mode rollover sets no overflow flag and no interrupt.
// - Baud mode trigger falling edge sets event flag, no reload.
// - Baud tick to UART is overflow rate divided by 16.
// - Rx and tx selects route overflow independently; else other timer.
// - Frequency generator rollovers raise no interrupt.
// - Baud and frequency generator run together on one reload value.
`timescale 1ns/1ps
`include "udt_consts.vh"

module udt_timer (
    input wire clk_in,
    input wire rstn_in,
    input wire ce_in,
    input wire [7:0] addr_in,
    input wire wr_in,
    input wire [7:0] wdata_in,
    output reg [7:0] rdata_out,
    input wire [3:0] prescale_select_in,
    input wire count_pin_in,
    output reg count_pin_out,
    output wire count_pin_oe_out,
    input wire trigger_pin_in,
    input wire other_rx_tick_in,
    input wire other_tx_tick_in,
    output reg rx_baud_tick_out,
    output reg tx_baud_tick_out,
    output wire irq_out
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] ctrl;
    reg [7:0] mode;
    reg [15:0] count;
    reg count_pin_q;
    reg trig_q;
    reg [3:0] ps_cnt;
    reg [3:0] rx_div;
    reg [3:0] tx_div;
    wire [15:0] reload_value;

    // Register select from the bus address
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    wire wr_ctrl = wr_in && hit(addr_in, `UDT_ADDR_CTRL);
    wire wr_mode = wr_in && hit(addr_in, `UDT_ADDR_MODE);
    wire wr_rcl = wr_in && hit(addr_in, `UDT_ADDR_RCL);
    wire wr_rch = wr_in && hit(addr_in, `UDT_ADDR_RCH);
    wire wr_cntl = wr_in && hit(addr_in, `UDT_ADDR_CNTL);
    wire wr_cnth = wr_in && hit(addr_in, `UDT_ADDR_CNTH);

    wire run = ctrl[`UDT_B_RUN];
    wire csel = ctrl[`UDT_B_CSEL];
    wire pin_en = ctrl[`UDT_B_PINEN];
    wire rxb = ctrl[`UDT_B_RXB];
    wire txb = ctrl[`UDT_B_TXB];
    wire clk_oe = mode[`UDT_B_CLKOE];
    wire down_count_enable = mode[`UDT_B_DOWN_COUNT_ENABLE];

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire baud_mode = run && (rxb || txb);
    wire cap_mode = run && !baud_mode && ctrl[`UDT_B_CAP];
    wire ud_mode = run && !baud_mode && !cap_mode && down_count_enable;
    wire up_mode = run && !baud_mode && !cap_mode && !down_count_enable;
    wire clkout = clk_oe && !csel;
    // Baud and clock-out rollovers raise no overflow flag
    wire ovf_quiet = baud_mode || clkout;

    // ------------------------------------------------------------
    // Edge detection and count enable
    // ------------------------------------------------------------
    function fall;
        input prev;
        input cur;
        begin
            fall = prev && !cur;
        end
    endfunction

    wire trig_fall = fall(trig_q, trigger_pin_in);
    wire pin_fall = fall(count_pin_q, count_pin_in);
    wire ps_tick = (ps_cnt == prescale_select_in);
    wire cnt_en = run && (csel ? pin_fall : ps_tick);
    wire ext_evt = pin_en && trig_fall;
    wire count_down = ud_mode && !trigger_pin_in;
    wire at_max = (count == `UDT_CNT_MAX);
    wire at_reload_value = (count == reload_value);
    wire wrap_up = cnt_en && !count_down && at_max;
    wire wrap_dn = cnt_en && count_down && at_reload_value;
    wire wrap = wrap_up || wrap_dn;

    // Capture into the reload pair only in capture mode
    wire do_capture = cap_mode && ext_evt;

    udt_byte_reg u_reload (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .wr_lo_in(wr_rcl),
        .wr_hi_in(wr_rch),
        .wdata_in(wdata_in),
        .cap_in(do_capture),
        .cap_data_in(count),
        .value_out(reload_value)
    );

    // ------------------------------------------------------------
    // Sampling and prescaler
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_pin_q <= 1'b0;
            trig_q <= 1'b0;
            ps_cnt <= `UDT_PS_ZERO;
        end else if (ce_in) begin
            // One sample per clock; edges found in the cycle the low sample is taken
            count_pin_q <= count_pin_in;
            trig_q <= trigger_pin_in;
            if (!run || ps_tick) begin
                ps_cnt <= `UDT_PS_ZERO;
            end else begin
                ps_cnt <= ps_cnt + `UDT_PS_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    reg [15:0] next_count;
    always @* begin
        next_count = count;
        if (cnt_en) begin
            if (count_down) begin
                next_count = count - `UDT_CNT_ONE;
            end else begin
                next_count = count + `UDT_CNT_ONE;
            end
            if (wrap_dn) begin
                next_count = `UDT_CNT_MAX;
            end else if (wrap_up && !cap_mode) begin
                next_count = reload_value;
            end
        end
        if (up_mode && ext_evt) begin
            next_count = reload_value;
        end
        // Bus writes to the count win over counting
        if (wr_cntl) begin
            next_count = {count[15:8], wdata_in};
        end
        if (wr_cnth) begin
            next_count = {wdata_in, count[7:0]};
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count <= `UDT_CNT_MIN;
        end else if (ce_in) begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // Control registers and flags
    // ------------------------------------------------------------
    reg next_ovf;
    reg next_ext;
    always @* begin
        next_ovf = ctrl[`UDT_B_OVF];
        next_ext = ctrl[`UDT_B_EXT];
        if (wr_ctrl) begin
            next_ovf = wdata_in[`UDT_B_OVF];
            next_ext = wdata_in[`UDT_B_EXT];
        end
        // Hardware set wins over a software clear
        if (wrap && !ovf_quiet) begin
            next_ovf = 1'b1;
        end
        if (ud_mode) begin
            if (wrap) begin
                next_ext = !ctrl[`UDT_B_EXT];
            end
        end else if (ext_evt && run) begin
            next_ext = 1'b1;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl <= `UDT_CTRL_RESET;
            mode <= `UDT_MODE_RESET;
        end else if (ce_in) begin
            // Software bits only; both flags come from the logic above
            if (wr_ctrl) begin
                ctrl[`UDT_CTRL_SW_MSB:0] <= wdata_in[`UDT_CTRL_SW_MSB:0];
            end
            ctrl[`UDT_B_OVF] <= next_ovf;
            ctrl[`UDT_B_EXT] <= next_ext;
            if (wr_mode) begin
                mode <= wdata_in & `UDT_MODE_MASK;
            end
        end
    end

    // Event flag raises no request in up/down mode
    assign irq_out = ctrl[`UDT_B_OVF] ||
        (ctrl[`UDT_B_EXT] && !ud_mode);

    // ------------------------------------------------------------
    // Baud ticks and clock output
    // ------------------------------------------------------------
    wire bwrap = baud_mode && wrap_up;

    // Tick on the last of sixteen baud rollovers
    function div_last;
        input [3:0] div;
        begin
            div_last = (div == `UDT_BAUD_DIV_LAST);
        end
    endfunction

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_div <= `UDT_PS_ZERO;
            tx_div <= `UDT_PS_ZERO;
            rx_baud_tick_out <= 1'b0;
            tx_baud_tick_out <= 1'b0;
            count_pin_out <= 1'b0;
        end else if (ce_in) begin
            rx_baud_tick_out <= other_rx_tick_in;
            tx_baud_tick_out <= other_tx_tick_in;
            if (rxb) begin
                rx_baud_tick_out <= 1'b0;
                if (bwrap) begin
                    rx_div <= rx_div + `UDT_BAUD_ONE;
                    rx_baud_tick_out <= div_last(rx_div);
                end
            end
            if (txb) begin
                tx_baud_tick_out <= 1'b0;
                if (bwrap) begin
                    tx_div <= tx_div + `UDT_BAUD_ONE;
                    tx_baud_tick_out <= div_last(tx_div);
                end
            end
            if (clkout && wrap) begin
                count_pin_out <= !count_pin_out;
            end
        end
    end

    assign count_pin_oe_out = clkout;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= `UDT_BYTE_ZERO;
        end else if (ce_in) begin
            // Zero for addresses outside the block
            case (addr_in)
                `UDT_ADDR_CTRL: rdata_out <= ctrl;
                `UDT_ADDR_MODE: rdata_out <= mode;
                `UDT_ADDR_RCL: rdata_out <= reload_value[7:0];
                `UDT_ADDR_RCH: rdata_out <= reload_value[15:8];
                `UDT_ADDR_CNTL: rdata_out <= count[7:0];
                `UDT_ADDR_CNTH: rdata_out <= count[15:8];
                default: rdata_out <= `UDT_BYTE_ZERO;
            endcase
        end
    end

endmodule

// >>> sim/udt_pins.sv
// Pin and companion-timer model on the timer's far side
`timescale 1ns/1ps
module udt_pins (
    input wire clk_in,
    input wire rstn_in,
    input wire oe_in,
    input wire drive_in,
    input wire fall_req_in,
    output wire pin_out,
    output wire rx_tick_out,
    output wire tx_tick_out
);
    logic [2:0] ph;
    logic [3:0] div;
    // Timer owns the pin only while enabled
    assign pin_out = oe_in ? drive_in : ph > 3'h2;
    assign rx_tick_out = rstn_in && div == 4'h0;
    assign tx_tick_out = rstn_in && div == 4'h7;
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ph <= 3'h0;
            div <= 4'h0;
        end else begin
            div <= div + 4'h1;
            // High two cycles, then low three or more
            ph <= ph != 3'h0 ? ph - 3'h1 : (fall_req_in ? 3'h4 : 3'h0);
        end
    end
endmodule

// >>> sim/udt_timer_chk.sv
// Port assertions for the reload capture timer
`timescale 1ns/1ps
module udt_timer_chk (
    input wire clk_in,
    input wire rstn_in,
    input wire ce_in,
    input wire [7:0] addr_in,
    input wire wr_in,
    input wire [7:0] wdata_in,
    input wire [7:0] rdata_out,
    input wire [3:0] prescale_select_in,
    input wire count_pin_oe_out,
    input wire other_rx_tick_in,
    input wire other_tx_tick_in,
    input wire rx_baud_tick_out,
    input wire tx_baud_tick_out,
    input wire irq_out
);
    logic [5:0] ctl;
    logic [1:0] md;
    logic quiet;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl <= 6'h00;
            md <= 2'h0;
            quiet <= 1'b0;
        end else if (wr_in && ce_in && addr_in == 8'hc8) begin
            ctl <= wdata_in[5:0];
            quiet <= wdata_in[7:6] == 2'h0 && !wdata_in[3] && |wdata_in[5:4];
        end else if (wr_in && ce_in && addr_in == 8'hc9) begin
            md <= wdata_in[1:0];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_pin_drive_enable: assert property (
        count_pin_oe_out == (md[1] && !ctl[1])) else $error("oe wrong");
    a_rx_other_route: assert property (
        $past(ce_in) && !$past(ctl[5]) |->
        rx_baud_tick_out == $past(other_rx_tick_in)) else $error("rx route");
    a_tx_other_route: assert property (
        $past(ce_in) && !$past(ctl[4]) |->
        tx_baud_tick_out == $past(other_tx_tick_in)) else $error("tx route");
    a_unmapped_read_zero: assert property (
        $past(ce_in) && ($past(addr_in) < 8'hc8 || $past(addr_in) > 8'hcd)
        |-> rdata_out == 8'h00) else $error("unmapped read");
    a_mode_read_back: assert property (
        $past(ce_in && addr_in == 8'hc9 && !wr_in) |->
        rdata_out == {6'h00, $past(md)}) else $error("mode read");
    a_ctrl_read_back: assert property (
        $past(ce_in && addr_in == 8'hc8 && !wr_in) |->
        rdata_out[5:0] == $past(ctl)) else $error("ctrl read");
    a_baud_no_irq: assert property (quiet |-> !irq_out)
        else $error("baud irq");
    a_count_step_one: assert property (
        $past(ce_in && addr_in == 8'hcc && !wr_in && !md[0] &&
        prescale_select_in == 4'h0 && ctl[3:1] == 3'h2, 2) &&
        $past(ce_in && addr_in == 8'hcc) && $past(rdata_out) != 8'hff
        |-> rdata_out == $past(rdata_out) + 8'h01) else $error("count step");
endmodule
bind udt_timer udt_timer_chk u_udt_timer_chk (.*);

// >>> sim/tb_updown_reload_capture_timer.sv
// Self-checking bench for the reload capture timer
`timescale 1ns/1ps
module tb_updown_reload_capture_timer;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic wr_in = 1'b0;
    logic [7:0] wdata_in = 8'h00;
    logic [3:0] ps = 4'h0;
    logic trig = 1'b1;
    logic ce = 1'b1;
    logic req = 1'b0;
    logic last;
    logic [7:0] mdl [0:6];
    logic [15:0] v;
    logic [15:0] r;
    wire [7:0] rdata_out;
    wire pin_o, pin_oe, pin_i, rx_o, tx_o, orx, otx, irq_out;
    integer bad_count = 0;
    integer check_count = 0;
    integer seed = 25169;
    integer i, n, m, p;
    udt_timer u_udt_timer (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
        .addr_in(addr_in), .wr_in(wr_in), .wdata_in(wdata_in),
        .rdata_out(rdata_out), .prescale_select_in(ps), .count_pin_in(pin_i),
        .count_pin_out(pin_o), .count_pin_oe_out(pin_oe),
        .trigger_pin_in(trig), .other_rx_tick_in(orx),
        .other_tx_tick_in(otx), .rx_baud_tick_out(rx_o),
        .tx_baud_tick_out(tx_o), .irq_out(irq_out));
    udt_pins u_udt_pins (.clk_in(clk_in), .rstn_in(rstn_in), .oe_in(pin_oe),
        .drive_in(pin_o), .fall_req_in(req), .pin_out(pin_i),
        .rx_tick_out(orx), .tx_tick_out(otx));
    initial forever #4 clk_in = ~clk_in;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count = check_count + 1;
        if (seen !== want) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        if (a > 8'hc7 && a < 8'hce)
            mdl[a - 8'hc7] = a == 8'hc9 ? d & 8'h03 : d;
        @(negedge clk_in);
        wr_in = 1'b0;
    endtask
    // Reads a byte pair, low address first
    task automatic rd(input logic [7:0] a);
        addr_in = a;
        @(negedge clk_in);
        v[7:0] = rdata_out;
        addr_in = a + 8'h01;
        @(negedge clk_in);
        v[15:8] = rdata_out;
    endtask
    initial begin
        for (i = 0; i < 7; i = i + 1) mdl[i] = 8'h00;
        repeat (2) @(negedge clk_in);
        rstn_in = 1'b1;
        rd(8'hc9);
        check(v[7:0], 8'h00);
        r = 16'($random(seed)) | 16'h8000;
        wr(8'hc7, 8'hff);
        wr(8'hc9, 8'hff);
        wr(8'hca, r[7:0]);
        wr(8'hcb, r[15:8]);
        for (i = 0; i < 7; i = i + 1) begin
            rd(8'hc7 + i[7:0]);
            check(v[7:0], mdl[i]);
        end
        wr(8'hc9, 8'h00);
        wr(8'hcc, 8'hf8);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h04);
        addr_in = 8'hcc;
        repeat (20) @(negedge clk_in);
        check(irq_out, 1'b1);
        wr(8'hc8, 8'h80);
        rd(8'hcc);
        check(16'(v - r < 16'h20), 16'h1);
        wr(8'hc8, 8'h0c);
        trig = 1'b0;
        @(negedge clk_in);
        check(irq_out, 1'b1);
        wr(8'hc8, 8'h00);
        trig = 1'b1;
        rd(8'hcc);
        check(16'(v - r < 16'h8), 16'h1);
        wr(8'hcc, 8'hfc);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h0d);
        repeat (8) @(negedge clk_in);
        trig = 1'b0;
        repeat (4) @(negedge clk_in);
        rd(8'hc8);
        check(v[7:0], 8'hcd);
        check(irq_out, 1'b1);
        rd(8'hca);
        check(16'(v < 16'h20), 16'h1);
        trig = 1'b1;
        wr(8'hc8, 8'h06);
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        for (i = 0; i < 5; i = i + 1) begin
            req = 1'b1;
            @(negedge clk_in);
            req = 1'b0;
            repeat (6) @(negedge clk_in);
        end
        wr(8'hc8, 8'h00);
        rd(8'hcc);
        check(v, 16'h0005);
        ce = 1'b0;
        wr(8'hcc, 8'haa);
        ce = 1'b1;
        rd(8'hcc);
        check(v, 16'h0005);
        wr(8'hc9, 8'h01);
        wr(8'hca, 8'h00);
        wr(8'hcb, 8'h01);
        wr(8'hcc, 8'hfd);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h0c);
        repeat (4) @(negedge clk_in);
        rd(8'hcc);
        check(v[15:8], 8'h01);
        trig = 1'b0;
        repeat (12) @(negedge clk_in);
        rd(8'hcc);
        check(v[15:8], 8'hff);
        rd(8'hc8);
        check(v[7:0], 8'h8c);
        wr(8'hc8, 8'h4c);
        check(irq_out, 1'b0);
        wr(8'hc8, 8'h00);
        trig = 1'b1;
        p = $random(seed) & 3;
        ps = p[3:0];
        wr(8'hc9, 8'h02);
        wr(8'hca, 8'hf0);
        wr(8'hcb, 8'hff);
        wr(8'hc8, 8'h34);
        repeat (64 * p + 64) @(negedge clk_in);
        n = 0;
        m = 0;
        last = pin_o;
        for (i = 0; i < 1024 * p + 1024; i = i + 1) begin
            @(negedge clk_in);
            n = n + rx_o + tx_o;
            m = m + (pin_o != last);
            last = pin_o;
        end
        check(n, 16'd8);
        check(m, 16'd64);
        wr(8'hc8, 8'h3c);
        trig = 1'b0;
        repeat (4) @(negedge clk_in);
        rd(8'hc8);
        check(v[7:0], 8'h7c);
        wr(8'hc8, 8'h04);
        trig = 1'b1;
        repeat (80 * p + 80) @(negedge clk_in);
        check(irq_out, 1'b0);
        wr(8'hc8, 8'h24);
        repeat (40) @(negedge clk_in);
        tally_and_finish;
    end
endmodule
